// ===== design/qscs_defines.svh
`ifndef QSCS_DEFINES_SVH
`define QSCS_DEFINES_SVH
`define QSCS_ADDR_CTRL 8'h00
`define QSCS_ADDR_STATUS 8'h04
`define QSCS_ADDR_RES01 8'h08
`define QSCS_ADDR_RES23 8'h0C
`define QSCS_RANGE_LSB 0
`define QSCS_LANES_LSB 12
`define QSCS_PDOWN_BIT 16
`define QSCS_RANGE_RST 12'hFFF
`define QSCS_LANES_RST 2'h3
`define QSCS_RANGE_OFF 3'h0
`define QSCS_RANGE_WIDEST 3'h7
`define QSCS_CODE_MSB 16'h8000
`define QSCS_CODE_LSB 16'h0001
`define QSCS_SIGN_FLIP 16'h8000
`define QSCS_FIRST_CH 2'h0
`define QSCS_LAST_CH 2'h3
`define QSCS_WORD_LAST 5'h17
`define QSCS_MCLK_NS 25
`define QSCS_SAMPLE_NS 2500
`define QSCS_CONV_CYCLES (`QSCS_SAMPLE_NS / `QSCS_MCLK_NS)
`endif

// ===== design/qscs_pkg.sv
`include "qscs_defines.svh"
package qscs_pkg;
  typedef enum logic [3:0] {
    QSCS_ACQ = 4'h1,
    QSCS_NEXT = 4'h2,
    QSCS_RUN = 4'h4,
    QSCS_PUB = 4'h8
  } qscs_state_t;
  typedef enum logic [1:0] {
    QSCS_IDLE = 2'h1,
    QSCS_STEP = 2'h2
  } qscs_sar_state_t;
  typedef logic [2:0] qscs_range_t;
  typedef logic [15:0] qscs_code_t;

  function automatic qscs_range_t qscsRangeOf(input logic [11:0] word, input logic [1:0] ch);
    return word[int'(ch) * 3 +: 3];
  endfunction

  // Bipolar codes are the four with the middle bit set, the widest among them included.
  function automatic logic qscsIsBipolar(input qscs_range_t r);
    return r[1];
  endfunction

  function automatic qscs_code_t qscsFormat(input qscs_code_t raw, input qscs_range_t r);
    if (r == `QSCS_RANGE_OFF) begin
      return '0;
    end
    return qscsIsBipolar(r) ? (raw ^ `QSCS_SIGN_FLIP) : raw;
  endfunction
endpackage

// ===== design/qscs_sar_if.sv
`timescale 1ns/1ps
`default_nettype none
interface qscs_sar_if;
  logic start;
  logic compHigh;
  logic done;
  qscs_pkg::qscs_code_t code;
  qscs_pkg::qscs_code_t trial;
  modport ctl(output start, output compHigh, input done, input code, input trial);
  modport eng(input start, input compHigh, output done, output code, output trial);
endinterface
`default_nettype wire

// ===== design/qscs_sar_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "qscs_defines.svh"
module qscs_sar_engine (
  input wire logic mclk,
  input wire logic resetn,
  qscs_sar_if.eng sar
);
  import qscs_pkg::*;
  // ==========================================================
  // Binary search
  qscs_sar_state_t state, next_state;
  qscs_code_t mask, next_mask, result, next_result, trial, next_trial, kept;
  logic done, next_done;

  always_comb begin
    next_state = state;
    next_mask = mask;
    next_result = result;
    next_trial = trial;
    next_done = 1'b0;
    kept = sar.compHigh ? trial : result;
    case (state)
      QSCS_IDLE: begin
        if (sar.start) begin
          next_result = '0;
          next_mask = `QSCS_CODE_MSB;
          next_trial = `QSCS_CODE_MSB;
          next_state = QSCS_STEP;
        end
      end
      QSCS_STEP: begin
        // Comparator high means the sample is at or above the trial level.
        next_result = kept; // [RL4]
        next_mask = mask >> 1;
        next_trial = kept | (mask >> 1);
        if (mask == `QSCS_CODE_LSB) begin
          next_done = 1'b1;
          next_state = QSCS_IDLE;
        end
      end
      default: next_state = QSCS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= QSCS_IDLE;
      mask <= '0;
      result <= '0;
      trial <= '0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      mask <= next_mask;
      result <= next_result;
      trial <= next_trial;
      done <= next_done;
    end
  end

  assign sar.done = done;
  assign sar.code = result;
  assign sar.trial = trial;

  // ==========================================================
  // Checks
  property p_search_len;
    @(posedge mclk) disable iff (!resetn) (state == QSCS_IDLE && sar.start) |-> ##17 done;
  endproperty
  a_search_len: assert property (p_search_len) else $error("Search did not take 16 steps."); // [RL4]
  property p_first_trial;
    @(posedge mclk) disable iff (!resetn)
      (state == QSCS_IDLE && sar.start) |=> trial == `QSCS_CODE_MSB ##1 trial[14];
  endproperty
  a_first_trial: assert property (p_first_trial) else $error("Search did not start at half."); // [RL4]
endmodule
`default_nettype wire

// ===== design/qscs_link_tx.sv
`timescale 1ns/1ps
`default_nettype none
`include "qscs_defines.svh"
module qscs_link_tx (
  input wire logic hostSerialClock,
  input wire logic resetn,
  input wire logic chipSelectN,
  input wire logic lvdsSelect,
  input wire logic convBusy,
  input wire logic [63:0] pubCodes,
  input wire logic [11:0] pubRange,
  input wire logic [1:0] pubLanes,
  output logic serialResultOut,
  output logic [3:0] laneOut,
  output logic [3:0] laneOe
);
  import qscs_pkg::*;
  logic [1:0] busySync, lvdsSync;
  logic active, next_active, evenBit, next_evenBit, oddPend, next_oddPend, oddBit;
  logic [63:0] fCodes, next_fCodes, srcCodes;
  logic [11:0] fRange, next_fRange, srcRange;
  logic [1:0] fLanes, next_fLanes, srcLanes, wordStep, next_wordStep, emitWord;
  logic [4:0] bitPos, next_bitPos, emitPos, step;
  logic [3:0] next_laneOut, next_laneOe;

  // Word per channel: result, channel number, range code; sent MSB first.
  function automatic logic wordBit(input logic [63:0] c, input logic [11:0] r,
                                   input logic [3:0] idx, input logic [4:0] pos);
    logic [23:0] w;
    w = {c[idx[1:0] * 16 +: 16], 1'b0, idx[1:0], 2'b00, qscsRangeOf(r, idx[1:0])};
    return idx[3:2] == 2'b00 ? w[`QSCS_WORD_LAST - pos] : 1'b0;
  endfunction

  always_comb begin
    // New results are taken only at a frame start and only outside a conversion.
    srcCodes = (!active && !busySync[1]) ? pubCodes : fCodes;
    srcRange = (!active && !busySync[1]) ? pubRange : fRange;
    srcLanes = (!active && !busySync[1]) ? pubLanes : fLanes;
    emitPos = active ? bitPos : 5'h00;
    emitWord = active ? wordStep : 2'h0;
    step = lvdsSync[1] ? 5'h02 : 5'h01; // [RL15]
    next_active = !chipSelectN;
    next_fCodes = srcCodes;
    next_fRange = srcRange;
    next_fLanes = srcLanes;
    next_bitPos = (emitPos + step > `QSCS_WORD_LAST) ? 5'h00 : emitPos + step;
    next_wordStep = (emitPos + step > `QSCS_WORD_LAST) ? emitWord + 2'h1 : emitWord;
    next_evenBit = wordBit(srcCodes, srcRange, {2'b00, emitWord}, emitPos); // [RL15]
    next_oddPend = wordBit(srcCodes, srcRange, {2'b00, emitWord}, emitPos + 5'h01);
    for (int l = 0; l < 4; l++) begin
      next_laneOe[l] = !chipSelectN && !lvdsSync[1] && (2'(l) <= srcLanes); // [RL10] [RL11]
      next_laneOut[l] = next_laneOe[l] &&
        wordBit(srcCodes, srcRange, 4'(l) + 4'({2'b00, srcLanes} + 4'h1) * {2'b00, emitWord},
                emitPos); // [RL11]
    end
    if (chipSelectN) begin
      next_fCodes = fCodes;
      next_fRange = fRange;
      next_fLanes = fLanes;
      next_bitPos = 5'h00;
      next_wordStep = 2'h0;
      next_evenBit = 1'b0;
      next_oddPend = 1'b0;
    end
  end

  always_ff @(posedge hostSerialClock or negedge resetn) begin
    if (!resetn) begin
      busySync <= 2'h0;
      lvdsSync <= 2'h0;
      fCodes <= '0;
      fRange <= '0;
      fLanes <= 2'h0;
    end else begin
      busySync <= {busySync[0], convBusy};
      lvdsSync <= {lvdsSync[0], lvdsSelect};
      fCodes <= next_fCodes;
      fRange <= next_fRange;
      fLanes <= next_fLanes;
    end
  end

  // The host stops its clock between frames, so deselect must end a frame without an edge.
  always_ff @(posedge hostSerialClock or negedge resetn or posedge chipSelectN) begin
    if (!resetn || chipSelectN) begin
      active <= 1'b0;
      bitPos <= 5'h00;
      wordStep <= 2'h0;
      evenBit <= 1'b0;
      oddPend <= 1'b0;
      laneOut <= 4'h0;
      laneOe <= 4'h0;
    end else begin
      active <= next_active;
      bitPos <= next_bitPos;
      wordStep <= next_wordStep;
      evenBit <= next_evenBit;
      oddPend <= next_oddPend;
      laneOut <= next_laneOut;
      laneOe <= next_laneOe;
    end
  end

  always_ff @(negedge hostSerialClock or negedge resetn) begin
    if (!resetn) begin
      oddBit <= 1'b0;
    end else begin
      oddBit <= oddPend;
    end
  end

  // Double data rate: the high phase carries the even bit, the low phase the odd bit.
  assign serialResultOut = hostSerialClock ? evenBit : oddBit; // [RL15]

  property p_cs_off;
    @(posedge hostSerialClock) disable iff (!resetn) chipSelectN |=> laneOe == 4'h0;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("Lanes driven while deselected."); // [RL10]
  property p_lvds_quiet;
    @(posedge hostSerialClock) disable iff (!resetn) lvdsSync[1] |=> laneOut == 4'h0;
  endproperty
  a_lvds_quiet: assert property (p_lvds_quiet) else $error("CMOS lanes active in LVDS mode."); // [RL10]
endmodule
`default_nettype wire

// ===== design/qscs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1: Channels track inputs during acquisition.
// RL2: Convert-start rising edge holds all channels together.
// RL3: Channels reach the shared DAC strictly in turn.
// RL4: Sixteen-step binary search per channel.
// RL5: Results published only after every channel finishes.
// RL6: Bipolar two's complement, unipolar straight binary.
// RL7: Per-channel range taken at each conversion start.
// RL8: Range seven is widest bipolar span.
// RL9: Disabled channels are skipped for throughput.
// RL10: A pin selects CMOS or LVDS output.
// RL11: CMOS output uses one to four lanes.
// RL12: Four channels convert within 400ksps period.
// RL13: Three-bit range codes; zero disables channel.
// RL14: Host packs four range codes into one word.
// RL15: LVDS sends results on both clock edges, channel 0 first.
// RL16: Host waits for conversion end before restarting.
`include "qscs_defines.svh"
module qscs_sequencer (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic convertStart,
  input wire logic compHigh,
  input wire logic lvdsSelect,
  input wire logic hostSerialClock,
  input wire logic chipSelectN,
  output logic [3:0] holdEnable,
  output logic [1:0] dacChannel,
  output var qscs_pkg::qscs_range_t dacSpan,
  output var qscs_pkg::qscs_code_t dacCode,
  output logic powerDown,
  output logic busy,
  output logic serialResultOut,
  output logic [3:0] laneOut,
  output logic [3:0] laneOe
);
  import qscs_pkg::*;

  // ==========================================================
  // Convert-start pin
  // The pin is asynchronous; only the second and third stages feed the edge detect.
  logic [2:0] cnvSync;
  logic cnvRise;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnvSync <= 3'h0;
    end else begin
      cnvSync <= {cnvSync[1:0], convertStart};
    end
  end

  assign cnvRise = cnvSync[1] & ~cnvSync[2]; // [RL2]

  // ==========================================================
  // Register bus
  logic [11:0] ctrlRange, next_ctrlRange;
  logic [1:0] ctrlLanes, next_ctrlLanes;
  logic ctrlPdown, next_ctrlPdown;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, apbWrite;
  logic [63:0] pubCodes, next_pubCodes;
  logic [11:0] pubRange, next_pubRange;
  logic [1:0] pubLanes, next_pubLanes;
  qscs_state_t state, next_state;

  always_comb begin
    next_ctrlRange = ctrlRange;
    next_ctrlLanes = ctrlLanes;
    next_ctrlPdown = ctrlPdown;
    next_prdata = prdata;
    next_pslverr = pslverr;
    // One wait state: the answer is registered in the first access cycle.
    next_pready = psel & penable & ~pready;
    apbWrite = psel & penable & pready & pwrite;
    if (next_pready) begin
      next_pslverr = 1'b0;
      case (paddr)
        `QSCS_ADDR_CTRL: begin
          next_prdata = {15'h0000, ctrlPdown, 2'h0, ctrlLanes, ctrlRange};
        end
        `QSCS_ADDR_STATUS: begin
          next_prdata = {24'h000000, busy, 1'b0, dacChannel, state};
        end
        `QSCS_ADDR_RES01: begin
          next_prdata = pubCodes[31:0];
        end
        `QSCS_ADDR_RES23: begin
          next_prdata = pubCodes[63:32];
        end
        default: begin
          next_prdata = 32'h00000000;
          next_pslverr = 1'b1;
        end
      endcase
    end
    // The range word may change at any time; a conversion already started keeps its own copy.
    if (apbWrite && paddr == `QSCS_ADDR_CTRL) begin
      next_ctrlRange = pwdata[`QSCS_RANGE_LSB +: 12]; // [RL13]
      next_ctrlLanes = pwdata[`QSCS_LANES_LSB +: 2]; // [RL11]
      next_ctrlPdown = pwdata[`QSCS_PDOWN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrlRange <= `QSCS_RANGE_RST;
      ctrlLanes <= `QSCS_LANES_RST;
      ctrlPdown <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrlRange <= next_ctrlRange;
      ctrlLanes <= next_ctrlLanes;
      ctrlPdown <= next_ctrlPdown;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign powerDown = ctrlPdown; // [RL12]

  // ==========================================================
  // Conversion sequencer
  qscs_sar_if sar ();
  logic [1:0] ch, next_ch;
  logic [3:0] next_hold;
  logic [11:0] latchedRange, next_latchedRange;
  qscs_range_t curRange, next_span;
  qscs_code_t codes [4];
  qscs_code_t next_codes [4];
  logic next_busy, lastCh, sarStart;

  always_comb begin
    next_state = state;
    next_ch = ch;
    next_hold = holdEnable;
    next_latchedRange = latchedRange;
    next_codes = codes;
    next_busy = busy;
    next_span = dacSpan;
    next_pubCodes = pubCodes;
    next_pubRange = pubRange;
    next_pubLanes = pubLanes;
    sarStart = 1'b0;
    curRange = qscsRangeOf(latchedRange, ch);
    lastCh = (ch == `QSCS_LAST_CH);
    case (state)
      QSCS_ACQ: begin
        next_hold = 4'h0; // [RL1]
        // Power-down ignores convert requests; the inputs keep tracking.
        if (cnvRise && !ctrlPdown) begin
          next_hold = 4'hF; // [RL2]
          next_latchedRange = ctrlRange; // [RL7]
          next_ch = `QSCS_FIRST_CH;
          next_busy = 1'b1;
          next_state = QSCS_NEXT;
        end
      end
      QSCS_NEXT: begin
        if (curRange != `QSCS_RANGE_OFF) begin
          // The CDAC span follows the channel's code; code seven spans twice the reference.
          next_span = curRange; // [RL8]
          sarStart = 1'b1; // [RL3]
          next_state = QSCS_RUN;
        end else begin
          next_codes[ch] = 16'h0000; // [RL9] [RL13]
          next_ch = ch + 2'h1;
          next_state = lastCh ? QSCS_PUB : QSCS_NEXT;
        end
      end
      QSCS_RUN: begin
        if (sar.done) begin
          next_codes[ch] = qscsFormat(sar.code, curRange); // [RL6]
          next_ch = ch + 2'h1; // [RL3]
          next_state = lastCh ? QSCS_PUB : QSCS_NEXT;
        end
      end
      QSCS_PUB: begin
        next_pubCodes = {codes[3], codes[2], codes[1], codes[0]}; // [RL5]
        next_pubRange = latchedRange;
        next_pubLanes = ctrlLanes;
        next_hold = 4'h0; // [RL1]
        next_busy = 1'b0;
        next_ch = `QSCS_FIRST_CH;
        next_state = QSCS_ACQ;
      end
      default: begin
        next_state = QSCS_ACQ;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= QSCS_ACQ;
      ch <= `QSCS_FIRST_CH;
      holdEnable <= 4'h0;
      latchedRange <= `QSCS_RANGE_RST;
      codes <= '{default: 16'h0000};
      busy <= 1'b0;
      dacSpan <= `QSCS_RANGE_WIDEST;
      pubCodes <= '0;
      pubRange <= `QSCS_RANGE_RST;
      pubLanes <= `QSCS_LANES_RST;
    end else begin
      state <= next_state;
      ch <= next_ch;
      holdEnable <= next_hold;
      latchedRange <= next_latchedRange;
      codes <= next_codes;
      busy <= next_busy;
      dacSpan <= next_span;
      pubCodes <= next_pubCodes;
      pubRange <= next_pubRange;
      pubLanes <= next_pubLanes;
    end
  end

  // The comparator sits in the same conversion clock domain, so it needs no synchroniser.
  assign sar.start = sarStart;
  assign sar.compHigh = compHigh;
  assign dacChannel = ch; // [RL3]
  assign dacCode = sar.trial; // [RL4]

  qscs_sar_engine u_engine (
    .mclk(mclk),
    .resetn(resetn),
    .sar(sar.eng)
  );

  // ==========================================================
  // Serial output
  // Results cross as a wide word that stays still while busy is low; busy crosses as a level.
  qscs_link_tx u_link (
    .hostSerialClock(hostSerialClock),
    .resetn(resetn),
    .chipSelectN(chipSelectN),
    .lvdsSelect(lvdsSelect),
    .convBusy(busy),
    .pubCodes(pubCodes),
    .pubRange(pubRange),
    .pubLanes(pubLanes),
    .serialResultOut(serialResultOut),
    .laneOut(laneOut),
    .laneOe(laneOe)
  );

  // ==========================================================
  // Checks
  logic [7:0] convCycles;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      convCycles <= 8'h00;
    end else begin
      convCycles <= busy ? convCycles + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_convStart;
    state == QSCS_ACQ && cnvRise && !ctrlPdown;
  endsequence

  property p_track;
    state == QSCS_ACQ |-> holdEnable == 4'h0;
  endproperty
  a_track: assert property (p_track) else $error("Channel held during acquisition."); // [RL1]

  property p_hold_all;
    s_convStart |=> holdEnable == 4'hF && busy;
  endproperty
  a_hold_all: assert property (p_hold_all) else $error("Channels not held together."); // [RL2]

  property p_one_channel;
    state == QSCS_RUN && !sar.done |=> state == QSCS_RUN && $stable(dacChannel);
  endproperty
  a_one_channel: assert property (p_one_channel) else $error("Channel moved mid-search."); // [RL3]

  property p_publish;
    state == QSCS_PUB |=> !busy && pubCodes == {codes[3], codes[2], codes[1], codes[0]};
  endproperty
  a_publish: assert property (p_publish) else $error("Results not published at end."); // [RL5]

  property p_format;
    state == QSCS_RUN && sar.done |=> codes[$past(ch)] ==
      ($past(curRange[1]) ? ($past(sar.code) ^ `QSCS_SIGN_FLIP) : $past(sar.code));
  endproperty
  a_format: assert property (p_format) else $error("Result format wrong for range."); // [RL6]

  property p_range_latch;
    s_convStart |=> latchedRange == $past(ctrlRange);
  endproperty
  a_range_latch: assert property (p_range_latch) else $error("Range not taken at start."); // [RL7]

  property p_skip;
    state == QSCS_NEXT && curRange == `QSCS_RANGE_OFF |-> !sar.start ##1
      codes[$past(ch)] == 16'h0000;
  endproperty
  a_skip: assert property (p_skip) else $error("Disabled channel was converted."); // [RL9]

  property p_rate;
    busy |-> convCycles < `QSCS_CONV_CYCLES;
  endproperty
  a_rate: assert property (p_rate) else $error("Conversion exceeded sample period."); // [RL12]
endmodule
`default_nettype wire

// ===== tb/qscs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host reading results over the serial link
module qscs_host_model (
  input wire logic lvdsMode,
  input wire logic [3:0] laneOut,
  input wire logic serialResultOut,
  output logic hostSerialClock,
  output logic chipSelectN
);
  logic [95:0] rx [4];
  initial begin
    hostSerialClock = 1'b0;
    chipSelectN = 1'b1;
  end
  // Deselected pulses only, so the link logic sees edges while it is in reset.
  task automatic idleClocks(input int n);
    #1;
    repeat (n) begin
      hostSerialClock = 1'b1;
      #62.5 hostSerialClock = 1'b0;
      #62.5;
    end
  endtask
  // The clock stands still outside frames; bits are taken mid-phase, clear of the edges.
  task automatic readFrame(input int clocks);
    chipSelectN = 1'b0;
    #40;
    for (int i = 0; i < clocks; i++) begin
      hostSerialClock = 1'b1;
      #31;
      if (lvdsMode) begin
        rx[0] = {rx[0][94:0], serialResultOut};
      end else begin
        for (int l = 0; l < 4; l++) begin
          rx[l] = {rx[l][94:0], laneOut[l]};
        end
      end
      #31.5 hostSerialClock = 1'b0;
      #31;
      if (lvdsMode) begin
        rx[0] = {rx[0][94:0], serialResultOut};
      end
      #31.5;
    end
    #40 chipSelectN = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== tb/quad_sar_conversion_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module quad_sar_conversion_sequencer_tb;
  import qscs_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic convertStart = 1'b0;
  logic lvdsSelect = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, compHigh, powerDown, busy, serialResultOut;
  logic hostSerialClock, chipSelectN;
  logic [3:0] holdEnable, laneOut, laneOe;
  logic [1:0] dacChannel;
  qscs_range_t dacSpan;
  qscs_code_t dacCode;
  logic [15:0] samp [4] = '{16'h1234, 16'hFEDC, 16'h7FFF, 16'h0001};
  logic [11:0] cfg;
  logic [31:0] rd;
  logic er;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int n4, n3;
  // Ideal comparator: the held sample of the channel on the DAC against the trial code.
  assign compHigh = (samp[dacChannel] >= dacCode);
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  qscs_sequencer uut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .convertStart(convertStart), .compHigh(compHigh),
    .lvdsSelect(lvdsSelect), .hostSerialClock(hostSerialClock), .chipSelectN(chipSelectN),
    .holdEnable(holdEnable), .dacChannel(dacChannel), .dacSpan(dacSpan), .dacCode(dacCode),
    .powerDown(powerDown), .busy(busy), .serialResultOut(serialResultOut),
    .laneOut(laneOut), .laneOe(laneOe));
  qscs_host_model host (.lvdsMode(lvdsSelect), .laneOut(laneOut),
    .serialResultOut(serialResultOut), .hostSerialClock(hostSerialClock),
    .chipSelectN(chipSelectN));
  task automatic tally_and_finish();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic checkVal(input string what, input logic [95:0] expv, input logic [95:0] got);
    compares++;
    if (got !== expv) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, expv, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [15:0] codeOf(input int ch);
    logic [2:0] r;
    logic [15:0] c;
    r = cfg[ch * 3 +: 3];
    c = (r == 3'h0) ? 16'h0000 : samp[ch];
    if (r == 3'h7 || r == 3'h6 || r == 3'h3 || r == 3'h2) c = c ^ 16'h8000;
    return c;
  endfunction
  function automatic logic [23:0] wordOf(input int ch);
    return {codeOf(ch), 1'b0, 2'(ch), 2'b00, cfg[ch * 3 +: 3]};
  endfunction
  task automatic convert(output int n);
    n = 0;
    @(posedge mclk);
    convertStart <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (busy !== 1'b1 && n < 10);
    checkVal("holdEnable", 4'hF, holdEnable);
    convertStart <= 1'b0;
    while (busy === 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    checkVal("holdEnable", 4'h0, holdEnable);
  endtask
  task automatic checkResults();
    for (int p = 0; p < 2; p++) begin
      apb(1'b0, 8'h08 + 8'(4 * p), 32'h0);
      checkVal("res", {codeOf(2 * p + 1), codeOf(2 * p)}, rd);
    end
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    fork
      host.idleClocks(3);
    join_none
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    checkVal("resetHold", 4'h0, holdEnable);
    checkVal("resetSpan", 3'h7, dacSpan);
    apb(1'b0, 8'h00, 32'h0);
    checkVal("ctrl", 32'h00003FFF, rd);
    apb(1'b0, 8'h10, 32'h0);
    checkVal("unmappedErr", 1'b1, er);
    checkVal("unmappedData", 32'h0, rd);
    $display("test reset done");
    cfg = 12'h2EF;
    apb(1'b1, 8'h00, 32'h000002EF);
    apb(1'b0, 8'h00, 32'h0);
    checkVal("ctrl", 32'h000002EF, rd);
    convert(n4);
    checkVal("fourChTime", 1'b1, n4 < 100);
    checkResults();
    fork
      host.readFrame(96);
      #500 checkVal("oneLaneOe", 4'h1, laneOe);
    join
    checkVal("oneLane", {wordOf(0), wordOf(1), wordOf(2), wordOf(3)}, host.rx[0]);
    $display("test all channels done");
    cfg = 12'h426;
    apb(1'b1, 8'h00, 32'h00003426);
    convert(n3);
    checkVal("skipFaster", 1'b1, n3 < n4);
    checkResults();
    fork
      host.readFrame(24);
      #500 checkVal("fourLaneOe", 4'hF, laneOe);
    join
    for (int l = 0; l < 4; l++) begin
      checkVal("fourLane", wordOf(l), host.rx[l][23:0]);
    end
    @(posedge mclk);
    checkVal("csOff", 4'h0, laneOe);
    $display("test disabled channel done");
    lvdsSelect <= 1'b1;
    host.idleClocks(4);
    fork
      host.readFrame(48);
      #500 checkVal("lvdsOe", 4'h0, laneOe);
    join
    checkVal("lvds", {wordOf(0), wordOf(1), wordOf(2), wordOf(3)}, host.rx[0]);
    apb(1'b1, 8'h00, 32'h00013426);
    @(negedge mclk);
    checkVal("powerDown", 1'b1, powerDown);
    $display("test lvds done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
